// >>> spra_alu.sv
`include "spra_regs.svh"

// saturating, pack, reverse, preload and stack datapath
module spra_alu
  import spra_pkg::*;
(
  input  wire logic     clk_in,         // core clock
  input  wire logic     rst_in,         // async reset, active high
  input  wire logic     req_valid_in,   // request offered
  input  spra_req_type  req_in,         // decoded request
  input  wire logic     mp_ext_in,      // multiprocessing extensions
  input  wire logic     hint_ready_in,  // cache can take a hint
  input  wire logic     flag_clear_in,  // status write clears flag
  output logic          req_ready_out,  // request can be taken
  output logic          res_valid_out,  // result word valid
  output logic [31:0]   res_data_out,   // result word
  output logic          sat_flag_out,   // sticky saturation flag
  output logic          hint_valid_out, // cache hint valid
  output spra_hint_type hint_out,       // cache hint
  output logic          xfer_valid_out, // stack transfer valid
  output spra_xfer_type xfer_out,       // stack transfer
  output logic          sp_wen_out,     // stack pointer write back
  output logic [31:0]   sp_data_out     // new stack pointer
);

  // saturate a 33-bit signed value to 32 bits
  function automatic logic [31:0] sat32(input logic [32:0] s);
    if (s[32] == s[31]) return s[31:0];
    return s[32] ? `SPRA_WORD_MIN : `SPRA_WORD_MAX;
  endfunction
  // overflow seen by sat32
  function automatic logic ovf33(input logic [32:0] s);
    return s[32] != s[31];
  endfunction
  spra_state_type  state_r;  // sequencer state
  spra_state_type  state_nxt;
  logic [15:0]     list_r;  // registers still to move
  logic [15:0]     list_nxt;
  logic [31:0]     addr_r;  // next transfer address
  logic            load_r;  // pop when high
  logic [31:0]     sp_final_r;  // stack pointer to write back
  logic            take;  // request accepted this cycle
  logic [31:0]     a;  // first source
  logic [31:0]     b;  // second source
  logic [31:0]     b_xchg;  // second source halves swapped
  logic [31:0]     packed_w;  // pack result
  logic [31:0]     lane_w;  // lane unit result
  logic [31:0]     rev_w;  // reversal unit result
  logic [32:0]     sum33;  // plain word add
  logic [32:0]     diff33;  // plain word subtract
  logic [31:0]     dbl;  // doubled second source
  logic            dbl_ovf;  // doubling clamped
  logic [32:0]     dsum33;  // first plus doubled
  logic [32:0]     ddiff33;  // first minus doubled
  logic            half_sel;  // lane width for lane unit
  logic [3:0]      byte_sub;  // byte lanes subtracting
  logic [1:0]      half_sub;  // halfword lanes subtracting
  spra_rev_type    rev_sel;  // reversal flavour
  logic [31:0]     result;  // word to register
  logic            result_ok;  // op writes a register
  logic            sat_set;  // clamp seen by flagging ops
  logic [31:0]     hint_off;  // hint offset magnitude
  logic [31:0]     hint_addr;  // computed hint address
  logic            hint_take;  // op is an issued hint
  spra_hint_kind_type hint_kind;  // hint flavour
  logic [4:0]      list_cnt;  // registers in request list
  logic [31:0]     span;  // bytes covered by the list
  logic [3:0]      low_idx;  // lowest pending register
  logic            low_found;  // any register pending
  assign a      = req_in.first;
  assign b      = req_in.second;
  assign b_xchg = {b[15:0], b[31:16]};
  // pipeline holds off while the stack sequencer runs
  assign take   = req_valid_in && req_ready_out;
  // RULE1: top of first, shifted bottom
  always_comb begin
    logic [31:0] shifted;
    shifted  = $signed(b) >>> req_in.shamt;
    packed_w = {a[31:16], shifted[15:0]};
  end
  // word adders, sign extended by one bit
  assign sum33   = {a[31], a} + {b[31], b};
  assign diff33  = {a[31], a} - {b[31], b};
  // RULE14: double with clamp first
  assign dbl     = sat32({b, 1'b0});
  assign dbl_ovf = ovf33({b, 1'b0});
  assign dsum33  = {a[31], a} + {dbl[31], dbl};
  assign ddiff33 = {a[31], a} - {dbl[31], dbl};
  // lane unit steering
  always_comb begin
    half_sel = 1'b0;
    byte_sub = 4'h0;
    half_sub = 2'h0;
    case (req_in.op)
      SPRA_OP_BYTE_SAT_SUB: byte_sub = 4'hF;
      SPRA_OP_HALF_SAT_ADD: half_sel = 1'b1;
      SPRA_OP_HALF_SAT_SUB: begin
        half_sel = 1'b1;
        half_sub = 2'h3;
      end
      // RULE12: add top, subtract bottom
      SPRA_OP_SAT_ADD_SUB_XCHG: begin
        half_sel = 1'b1;
        half_sub = 2'h1;
      end
      // RULE13: subtract top, add bottom
      SPRA_OP_SAT_SUB_ADD_XCHG: begin
        half_sel = 1'b1;
        half_sub = 2'h2;
      end
      default: half_sel = 1'b0;
    endcase
  end

  // exchange variants see the swapped second source
  spra_lane_sat u_lane (
    .a_in    (a),
    .b_in    ((req_in.op == SPRA_OP_SAT_ADD_SUB_XCHG ||
               req_in.op == SPRA_OP_SAT_SUB_ADD_XCHG) ? b_xchg : b),
    .half_in (half_sel),
    .sub_in  (byte_sub),
    .hsub_in (half_sub),
    .res_out (lane_w)
  );

  // reversal flavour select
  always_comb begin
    case (req_in.op)
      SPRA_OP_WORD_BYTE_REVERSAL:   rev_sel = SPRA_REV_WORD;
      SPRA_OP_HALF_BYTE_REVERSAL:   rev_sel = SPRA_REV_HALF;
      SPRA_OP_SIGNED_HALF_REVERSAL: rev_sel = SPRA_REV_SHALF;
      default:                      rev_sel = SPRA_REV_BITS;
    endcase
  end

  spra_reverse u_rev (
    .data_in (a),
    .sel_in  (rev_sel),
    .res_out (rev_w)
  );
  // result mux and saturation detect
  always_comb begin
    result    = `SPRA_ZERO_WORD;
    result_ok = 1'b1;
    sat_set   = 1'b0;
    case (req_in.op)
      SPRA_OP_PACK_TOP_BOTTOM: result = packed_w;
      // RULE9: word add clamp, flag
      SPRA_OP_SAT_ADD: begin
        result  = sat32(sum33);
        sat_set = ovf33(sum33);
      end
      // RULE16: word subtract clamp, flag
      SPRA_OP_SAT_SUB: begin
        result  = sat32(diff33);
        sat_set = ovf33(diff33);
      end
      // RULE14: either clamp flags
      SPRA_OP_SAT_DOUBLING_ADD: begin
        result  = sat32(dsum33);
        sat_set = dbl_ovf || ovf33(dsum33);
      end
      // RULE15: doubled then subtracted
      SPRA_OP_SAT_DOUBLING_SUB: begin
        result  = sat32(ddiff33);
        sat_set = dbl_ovf || ovf33(ddiff33);
      end
      // lane ops never touch the flag
      SPRA_OP_BYTE_SAT_ADD, SPRA_OP_BYTE_SAT_SUB,
      SPRA_OP_HALF_SAT_ADD, SPRA_OP_HALF_SAT_SUB,
      SPRA_OP_SAT_ADD_SUB_XCHG, SPRA_OP_SAT_SUB_ADD_XCHG: result = lane_w;
      SPRA_OP_BIT_REVERSAL, SPRA_OP_WORD_BYTE_REVERSAL,
      SPRA_OP_HALF_BYTE_REVERSAL, SPRA_OP_SIGNED_HALF_REVERSAL: result = rev_w;
      // RULE2: hints and stack ops return no word
      default: result_ok = 1'b0;
    endcase
  end
  // RULE5: base plus immediate or shifted register
  assign hint_off  = req_in.use_reg ? (b << req_in.shamt[4:0])
                                    : {20'h00000, req_in.imm};
  assign hint_addr = req_in.sub_off ? (a - hint_off) : (a + hint_off);
  // hint selection; no exception path exists at all
  always_comb begin
    hint_take = 1'b0;
    hint_kind = SPRA_HINT_DATA;
    case (req_in.op)
      SPRA_OP_DATA_PRELOAD: hint_take = 1'b1;
      // RULE3: only with multiprocessing extensions
      SPRA_OP_PRELOAD_FOR_WRITE: begin
        hint_take = mp_ext_in;
        hint_kind = SPRA_HINT_WRITE;
      end
      // RULE4: instruction fetch hint only
      SPRA_OP_INSTR_PRELOAD: begin
        hint_take = 1'b1;
        hint_kind = SPRA_HINT_INSTR;
      end
      default: hint_take = 1'b0;
    endcase
  end
  // register list population count
  always_comb begin
    list_cnt = `SPRA_ZERO_CNT;
    for (int i = 0; i < `SPRA_REG_COUNT; i++) begin
      list_cnt = list_cnt + {4'h0, req_in.reglist[i]};
    end
    span = {25'h0000000, list_cnt, 2'b00};
  end

  // lowest register still pending
  always_comb begin
    low_idx   = `SPRA_ZERO_IDX;
    low_found = 1'b0;
    for (int i = `SPRA_REG_COUNT - 1; i >= 0; i--) begin
      if (list_r[i]) begin
        low_idx   = 4'(i);
        low_found = 1'b1;
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    list_nxt  = list_r;
    case (state_r)
      SPRA_ST_IDLE: begin
        if (take && (req_in.op == SPRA_OP_STACK_POP ||
                     req_in.op == SPRA_OP_STACK_PUSH) &&
            req_in.reglist != 16'h0000) begin
          state_nxt = SPRA_ST_XFER;
          list_nxt  = req_in.reglist;
        end
      end
      SPRA_ST_XFER: begin
        list_nxt = list_r & ~(16'h0001 << low_idx);
        if (list_nxt == 16'h0000) begin
          state_nxt = SPRA_ST_IDLE;
        end
      end
      default: state_nxt = SPRA_ST_IDLE;
    endcase
  end
  // sequencer state, list and ready; ready drops for the burst
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r       <= SPRA_ST_IDLE;
      list_r        <= 16'h0000;
      req_ready_out <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      list_r        <= list_nxt;
      req_ready_out <= (state_nxt == SPRA_ST_IDLE);
    end
  end

  // transfer addressing; lowest register sits at lowest address
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      addr_r     <= `SPRA_ZERO_WORD;
      load_r     <= 1'b0;
      sp_final_r <= `SPRA_ZERO_WORD;
    end else if (state_r == SPRA_ST_IDLE && state_nxt == SPRA_ST_XFER) begin
      load_r <= (req_in.op == SPRA_OP_STACK_POP);
      if (req_in.op == SPRA_OP_STACK_POP) begin
        // RULE7: start at sp, increment after
        addr_r     <= a;
        sp_final_r <= a + span;
      end else begin
        // RULE8: decrement before, full descending
        addr_r     <= a - span;
        sp_final_r <= a - span;
      end
    end else if (state_r == SPRA_ST_XFER) begin
      addr_r <= addr_r + `SPRA_WORD_BYTES;
    end
  end

  // transfer and write back outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xfer_valid_out <= 1'b0;
      xfer_out       <= '0;
      sp_wen_out     <= 1'b0;
      sp_data_out    <= `SPRA_ZERO_WORD;
    end else begin
      xfer_valid_out   <= (state_r == SPRA_ST_XFER) && low_found;
      xfer_out.load    <= load_r;
      xfer_out.reg_idx <= low_idx;
      xfer_out.addr    <= addr_r;
      // RULE7: final address written back
      // RULE8: final address written back
      sp_wen_out  <= (state_r == SPRA_ST_XFER) && (state_nxt == SPRA_ST_IDLE);
      sp_data_out <= sp_final_r;
    end
  end

  // registered word result
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      res_valid_out <= 1'b0;
      res_data_out  <= `SPRA_ZERO_WORD;
    end else begin
      res_valid_out <= take && result_ok;
      if (take && result_ok) begin
        res_data_out <= result;
      end
    end
  end

  // RULE24: busy cache simply drops the hint
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hint_valid_out <= 1'b0;
      hint_out       <= '0;
    end else begin
      hint_valid_out <= take && hint_take && hint_ready_in;
      if (take && hint_take) begin
        hint_out.kind <= hint_kind;
        hint_out.addr <= hint_addr;
      end
    end
  end

  // RULE23: sticky flag, set beats clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sat_flag_out <= 1'b0;
    end else if (take && sat_set) begin
      sat_flag_out <= 1'b1;
    end else if (flag_clear_in) begin
      sat_flag_out <= 1'b0;
    end
  end

endmodule // spra_alu

// >>> spra_alu_asserts.sv
// port checks of the datapath
module spra_chk
  import spra_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        req_valid_in,
  input spra_req_type     req_in,
  input wire logic        mp_ext_in,
  input wire logic        hint_ready_in,
  input wire logic        flag_clear_in,
  input wire logic        req_ready_out,
  input wire logic        res_valid_out,
  input wire logic [31:0] res_data_out,
  input wire logic        sat_flag_out,
  input wire logic        hint_valid_out,
  input wire logic        xfer_valid_out,
  input spra_xfer_type    xfer_out,
  input wire logic        sp_wen_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic        tk;   // request taken at this edge
  logic        hn;   // request is a preload hint
  logic [31:0] sm;   // unclamped word sum
  logic [31:0] a_r;  // first operand one edge back
  assign tk = req_valid_in && req_ready_out;
  assign hn = req_in.op inside {SPRA_OP_DATA_PRELOAD,
    SPRA_OP_PRELOAD_FOR_WRITE, SPRA_OP_INSTR_PRELOAD};
  assign sm = req_in.first + req_in.second;
  // operand copy
  always_ff @(posedge clk_in) begin
    a_r <= req_in.first;
  end
  // lane op, no clear
  sequence s_lane;
    tk && !flag_clear_in && req_in.op inside {SPRA_OP_BYTE_SAT_SUB,
      [SPRA_OP_BYTE_SAT_ADD:SPRA_OP_SAT_SUB_ADD_XCHG],
      SPRA_OP_HALF_SAT_SUB};
  endsequence
  // stack op with a non-empty list
  sequence s_stk;
    tk && req_in.op inside {SPRA_OP_STACK_PUSH, SPRA_OP_STACK_POP}
      && |req_in.reglist;
  endsequence
  chk_pack_top: assert property (
    tk && req_in.op == SPRA_OP_PACK_TOP_BOTTOM
    |=> res_valid_out && res_data_out[31:16] == a_r[31:16])
    else $error("pack upper half wrong");
  chk_hint_quiet: assert property (tk && hn |=> !res_valid_out)
    else $error("hint gave a result");
  chk_write_gate: assert property (
    tk && req_in.op == SPRA_OP_PRELOAD_FOR_WRITE && !mp_ext_in
    |=> !hint_valid_out)
    else $error("write hint without extensions");
  chk_hint_drop: assert property (
    tk && hn && !hint_ready_in |=> !hint_valid_out)
    else $error("hint issued while cache busy");
  chk_add_flag: assert property (
    tk && req_in.op == SPRA_OP_SAT_ADD
    && req_in.first[31] == req_in.second[31] && sm[31] != req_in.first[31]
    |=> sat_flag_out)
    else $error("overflow left flag clear");
  chk_lane_flag: assert property (s_lane |=> $stable(sat_flag_out))
    else $error("lane op moved flag");
  chk_flag_sticky: assert property (
    sat_flag_out && !flag_clear_in |=> sat_flag_out)
    else $error("flag dropped without clear");
  chk_stack_busy: assert property (
    s_stk |=> !req_ready_out ##1 xfer_valid_out)
    else $error("stack burst timing wrong");
  chk_xfer_step: assert property (
    xfer_valid_out && !sp_wen_out |=> xfer_valid_out
    && xfer_out.addr == $past(xfer_out.addr) + 32'h00000004)
    else $error("stack word gap or step wrong");
endmodule // spra_chk

bind spra_alu spra_chk u_chk (.*);

// >>> spra_lane_sat.sv
`include "spra_regs.svh"

// lane saturating add or subtract over bytes or halfwords
module spra_lane_sat
  import spra_pkg::*;
(
  input  wire logic [31:0] a_in,    // first source
  input  wire logic [31:0] b_in,    // second source, halves swapped for the exchange ops
  input  wire logic        half_in, // halfword lanes when high
  input  wire logic [3:0]  sub_in,  // per byte lane subtract
  input  wire logic [1:0]  hsub_in, // per halfword lane subtract
  output logic      [31:0] res_out  // clamped lane results
);

  logic [31:0] byte_res;  // four byte lane results
  logic [31:0] half_res;  // two halfword lane results

  // byte lanes, 9-bit sum catches overflow
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte
      logic [8:0] s;
      always_comb begin
        if (sub_in[gi]) begin
          s = {a_in[8*gi+7], a_in[8*gi +: 8]} - {b_in[8*gi+7], b_in[8*gi +: 8]};
        end else begin
          s = {a_in[8*gi+7], a_in[8*gi +: 8]} + {b_in[8*gi+7], b_in[8*gi +: 8]};
        end
      end
      // RULE10: byte add clamp
      // RULE17: byte subtract clamp
      assign byte_res[8*gi +: 8] = (s[8] == s[7]) ? s[7:0] :
                                   (s[8] ? `SPRA_BYTE_MIN : `SPRA_BYTE_MAX);
    end
    for (gi = 0; gi < 2; gi++) begin : g_half
      logic [16:0] s;
      always_comb begin
        if (hsub_in[gi]) begin
          s = {a_in[16*gi+15], a_in[16*gi +: 16]}
            - {b_in[16*gi+15], b_in[16*gi +: 16]};
        end else begin
          s = {a_in[16*gi+15], a_in[16*gi +: 16]}
            + {b_in[16*gi+15], b_in[16*gi +: 16]};
        end
      end
      // RULE11: halfword add clamp
      // RULE18: halfword subtract clamp
      assign half_res[16*gi +: 16] = (s[16] == s[15]) ? s[15:0] :
                                     (s[16] ? `SPRA_HALF_MIN : `SPRA_HALF_MAX);
    end
  endgenerate

  // lane width select
  assign res_out = half_in ? half_res : byte_res;

endmodule // spra_lane_sat

// >>> spra_pipe_model.sv
// pipeline side: offers one request and holds it until taken
module spra_pipe_model
  import spra_pkg::*;
(
  input  wire logic    clk_in,     // core clock
  input  wire logic    send_in,    // one-cycle order from the bench
  input  spra_req_type cmd_in,     // request to offer
  input  wire logic    ready_in,   // block can take a request
  output logic         valid_out,  // request offered
  output spra_req_type req_out,    // offered request
  output logic         taken_out   // taken at the last edge
);
  initial begin
    valid_out = 1'b0;
    taken_out = 1'b0;
    req_out = '0;
  end
  // offset register
  // only decoded values travel, never a register name
  always @(posedge clk_in) begin
    taken_out <= valid_out && ready_in;
    if (send_in) begin
      valid_out <= 1'b1;
      req_out <= cmd_in;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'b0;
    end
  end
endmodule // spra_pipe_model

// >>> spra_pkg.sv
package spra_pkg;

  // operation selector issued by the pipeline
  typedef enum logic [4:0] {
    SPRA_OP_PACK_TOP_BOTTOM = 5'h00,
    SPRA_OP_DATA_PRELOAD = 5'h01,
    SPRA_OP_PRELOAD_FOR_WRITE = 5'h02,
    SPRA_OP_INSTR_PRELOAD = 5'h03,
    SPRA_OP_STACK_POP = 5'h04,
    SPRA_OP_STACK_PUSH = 5'h05,
    SPRA_OP_SAT_ADD = 5'h06,
    SPRA_OP_BYTE_SAT_ADD = 5'h07,
    SPRA_OP_HALF_SAT_ADD = 5'h08,
    SPRA_OP_SAT_ADD_SUB_XCHG = 5'h09,
    SPRA_OP_SAT_SUB_ADD_XCHG = 5'h0A,
    SPRA_OP_SAT_DOUBLING_ADD = 5'h0B,
    SPRA_OP_SAT_DOUBLING_SUB = 5'h0C,
    SPRA_OP_SAT_SUB = 5'h0D,
    SPRA_OP_BYTE_SAT_SUB = 5'h0E,
    SPRA_OP_HALF_SAT_SUB = 5'h0F,
    SPRA_OP_BIT_REVERSAL = 5'h10,
    SPRA_OP_WORD_BYTE_REVERSAL = 5'h11,
    SPRA_OP_HALF_BYTE_REVERSAL = 5'h12,
    SPRA_OP_SIGNED_HALF_REVERSAL = 5'h13
  } spra_op_type;

  // reversal flavour for the reversal unit
  typedef enum logic [1:0] {
    SPRA_REV_BITS  = 2'h0,
    SPRA_REV_WORD  = 2'h1,
    SPRA_REV_HALF  = 2'h2,
    SPRA_REV_SHALF = 2'h3
  } spra_rev_type;

  // kind of cache hint sent out
  typedef enum logic [1:0] {
    SPRA_HINT_DATA  = 2'h0,
    SPRA_HINT_WRITE = 2'h1,
    SPRA_HINT_INSTR = 2'h2
  } spra_hint_kind_type;

  // stack transfer sequencer states
  typedef enum logic [0:0] {
    SPRA_ST_IDLE = 1'b0,
    SPRA_ST_XFER = 1'b1
  } spra_state_type;

  // decoded request from the pipeline
  typedef struct packed {
    spra_op_type  op;
    logic [31:0]  first;     // first source, base or stack pointer
    logic [31:0]  second;    // second source or offset register
    logic [5:0]   shamt;     // shift amount
    logic [15:0]  reglist;   // stack register list
    logic         use_reg;   // hint offset from register
    logic         sub_off;   // hint offset subtracted
    logic [11:0]  imm;       // hint immediate offset
  } spra_req_type;

  // cache hint toward the memory side
  typedef struct packed {
    spra_hint_kind_type kind;
    logic [31:0]        addr;
  } spra_hint_type;

  // one word of a stack transfer
  typedef struct packed {
    logic        load;
    logic [3:0]  reg_idx;
    logic [31:0] addr;
  } spra_xfer_type;

endpackage

// >>> spra_regs.svh
// Operation
// RULE1: pack top half, shifted bottom half
// RULE2: data preload hint, no register result
// RULE3: write preload only with multiprocessing extensions
// RULE4: instruction preload hint changes no register
// RULE5: hint address base plus offset
// RULE6: pipeline never names forbidden offset registers
// RULE7: pop loads ascending, writes back sp
// RULE8: push stores descending, writes back sp
// RULE9: saturating word add sets sticky flag
// RULE10: four byte adds clamped, flag untouched
// RULE11: two halfword adds clamped, flag untouched
// RULE12: exchange, add top, subtract bottom
// RULE13: exchange, subtract top, add bottom
// RULE14: doubling add, flag on either clamp
// RULE15: doubling subtract, flag on either clamp
// RULE16: saturating word subtract sets sticky flag
// RULE17: four byte subtracts clamped, flag untouched
// RULE18: two halfword subtracts clamped, flag untouched
// RULE19: mirror all 32 bit positions
// RULE20: reverse four bytes of word
// RULE21: swap bytes inside each halfword
// RULE22: swap low halfword bytes, sign extend
// RULE23: saturation flag only set here, cleared explicitly
// RULE24: hints never fault, may be dropped
`ifndef SPRA_REGS_SVH
`define SPRA_REGS_SVH

// signed word limits
`define SPRA_WORD_MAX   32'h7FFFFFFF
`define SPRA_WORD_MIN   32'h80000000
// signed halfword limits
`define SPRA_HALF_MAX   16'h7FFF
`define SPRA_HALF_MIN   16'h8000
// signed byte limits
`define SPRA_BYTE_MAX   8'h7F
`define SPRA_BYTE_MIN   8'h80

// reset values
`define SPRA_ZERO_WORD  32'h00000000
`define SPRA_ZERO_CNT   5'h00
`define SPRA_ZERO_IDX   4'h0

// register list width and last index
`define SPRA_REG_COUNT  16
`define SPRA_REG_LAST   4'hF
// bytes per stacked word
`define SPRA_WORD_BYTES 32'h00000004

`endif

// >>> spra_reverse.sv
`include "spra_regs.svh"

// bit and byte reversal unit, purely combinational
module spra_reverse
  import spra_pkg::*;
(
  input  wire logic [31:0]  data_in,    // source word
  input  spra_rev_type      sel_in,     // reversal flavour
  output logic      [31:0]  res_out     // reversed word
);

  logic [31:0] mirror;    // bit mirrored source
  logic [15:0] low_swap;  // low halfword bytes swapped

  // RULE19: mirror bit positions
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_bit
      assign mirror[gi] = data_in[31-gi];
    end
  endgenerate

  assign low_swap = {data_in[7:0], data_in[15:8]};

  // flavour select
  always_comb begin
    case (sel_in)
      SPRA_REV_BITS:  res_out = mirror;
      // RULE20: four bytes reversed
      SPRA_REV_WORD:  res_out = {data_in[7:0], data_in[15:8],
                                 data_in[23:16], data_in[31:24]};
      // RULE21: bytes swapped per half
      SPRA_REV_HALF:  res_out = {data_in[23:16], data_in[31:24], low_swap};
      // RULE22: swap then sign extend
      SPRA_REV_SHALF: res_out = {{16{low_swap[15]}}, low_swap};
      default:        res_out = data_in;
    endcase
  end

endmodule // spra_reverse

// >>> testbench.sv
module testbench import spra_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, rst_in, send, taken, mp_ext, hint_rdy, flag_clr;
  logic req_valid, req_ready, res_valid, sat_flag, hint_valid;
  logic xfer_valid, sp_wen;
  logic [31:0] res_data, sp_data, sp_q;
  spra_req_type  cmd, req;
  spra_hint_type hint;
  spra_xfer_type xfer;
  logic [31:0] rq[$];  // result words seen
  logic [33:0] hq[$];  // hints seen
  logic [36:0] xq[$];  // stack words seen
  int failures, checks_done;
  spra_pipe_model u_pipe (.clk_in, .send_in(send), .cmd_in(cmd),
    .ready_in(req_ready), .valid_out(req_valid), .req_out(req),
    .taken_out(taken));
  spra_alu u_dut (.clk_in, .rst_in, .req_valid_in(req_valid),
    .req_in(req), .mp_ext_in(mp_ext), .hint_ready_in(hint_rdy),
    .flag_clear_in(flag_clr), .req_ready_out(req_ready),
    .res_valid_out(res_valid), .res_data_out(res_data),
    .sat_flag_out(sat_flag), .hint_valid_out(hint_valid),
    .hint_out(hint), .xfer_valid_out(xfer_valid), .xfer_out(xfer),
    .sp_wen_out(sp_wen), .sp_data_out(sp_data));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // collect one-cycle outputs
  always @(posedge clk_in) begin
    if (res_valid) rq.push_back(res_data);
    if (hint_valid) hq.push_back(hint);
    if (xfer_valid) xq.push_back(xfer);
    if (sp_wen) sp_q = sp_data;
  end
  task automatic cmp(logic [39:0] g, logic [39:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // x packs use_reg, sub_off and imm
  task automatic go(spra_op_type o, logic [31:0] a, logic [31:0] b,
                    logic [5:0] s, logic [15:0] l, logic [13:0] x);
    int n;
    rq.delete();
    hq.delete();
    xq.delete();
    @(posedge clk_in) #1;
    cmd = {o, a, b, s, l, x};
    send = 1'b1;
    @(posedge clk_in) #1;
    send = 1'b0;
    n = 0;
    while (!taken && n < 40) begin
      @(posedge clk_in) #1;
      n++;
    end
    if (!taken) cmp(40'h0, 40'h1);
    // a 16-word burst ends well inside this span
    repeat (20) @(posedge clk_in);
    #1;
  endtask
  task automatic clr;
    @(posedge clk_in) #1;
    flag_clr = 1'b1;
    @(posedge clk_in) #1;
    flag_clr = 1'b0;
  endtask
  task automatic t_pack;
    go(SPRA_OP_PACK_TOP_BOTTOM, 32'h1234ABCD, 32'h80000000, 6'h20,
       16'h0, 14'h0);
    cmp(rq[0], 32'h1234FFFF);
    go(SPRA_OP_PACK_TOP_BOTTOM, 32'h1234ABCD, 32'h2, 6'h1, 16'h0, 14'h0);
    cmp(rq[0], 32'h12340001);
  endtask
  task automatic t_word;
    spra_op_type o[4] = '{SPRA_OP_SAT_ADD, SPRA_OP_SAT_SUB,
      SPRA_OP_SAT_DOUBLING_ADD, SPRA_OP_SAT_DOUBLING_SUB};
    logic [31:0] a[4] = '{32'h7FFFFFFF, 32'h80000000, 32'h0, 32'h0};
    logic [31:0] b[4] = '{32'h1, 32'h1, 32'h40000000, 32'hC0000000};
    logic [31:0] e[4] = '{32'h7FFFFFFF, 32'h80000000, 32'h7FFFFFFF,
      32'h7FFFFFFF};
    for (int k = 0; k < 4; k++) begin
      clr;
      go(o[k], a[k], b[k], 6'h0, 16'h0, 14'h0);
      cmp(rq[0], e[k]);
      cmp(sat_flag, 1'b1);
      go(SPRA_OP_SAT_ADD, 32'h1, 32'h1, 6'h0, 16'h0, 14'h0);
      cmp(sat_flag, 1'b1);
    end
  endtask
  task automatic t_lane;
    spra_op_type o[6] = '{SPRA_OP_BYTE_SAT_ADD, SPRA_OP_BYTE_SAT_SUB,
      SPRA_OP_HALF_SAT_ADD, SPRA_OP_HALF_SAT_SUB,
      SPRA_OP_SAT_ADD_SUB_XCHG, SPRA_OP_SAT_SUB_ADD_XCHG};
    logic [31:0] a[6] = '{32'h7F80017F, 32'h7F800000, 32'h7FFF8000,
      32'h80007FFF, 32'h00100010, 32'h00100010};
    logic [31:0] b[6] = '{32'h01FF0280, 32'hFF010102, 32'h00018000,
      32'h0001FFFF, 32'h00020001, 32'h00020001};
    logic [31:0] e[6] = '{32'h7F8003FF, 32'h7F80FFFE, 32'h7FFF8000,
      32'h80007FFF, 32'h0011000E, 32'h000F0012};
    clr;
    for (int k = 0; k < 6; k++) begin
      go(o[k], a[k], b[k], 6'h0, 16'h0, 14'h0);
      cmp(rq[0], e[k]);
      cmp(sat_flag, 1'b0);
    end
  endtask
  task automatic t_rev;
    logic [31:0] e[4] = '{32'h816A2C48, 32'h81563412, 32'h34128156,
      32'hFFFF8156};
    for (int k = 0; k < 4; k++) begin
      go(spra_op_type'(k + 16), 32'h12345681, 32'h0, 6'h0, 16'h0, 14'h0);
      cmp(rq[0], e[k]);
    end
  endtask
  task automatic t_hint;
    go(SPRA_OP_DATA_PRELOAD, 32'h1000, 32'h0, 6'h0, 16'h0, 14'h010);
    cmp(hq[0], {SPRA_HINT_DATA, 32'h1010});
    cmp(rq.size(), 0);
    go(SPRA_OP_INSTR_PRELOAD, 32'h1000, 32'h4, 6'h2, 16'h0, 14'h3000);
    cmp(hq[0], {SPRA_HINT_INSTR, 32'h0FF0});
    cmp(rq.size(), 0);
    go(SPRA_OP_PRELOAD_FOR_WRITE, 32'h2000, 32'h0, 6'h0, 16'h0, 14'h0);
    cmp(hq[0], {SPRA_HINT_WRITE, 32'h2000});
    mp_ext = 1'b0;
    go(SPRA_OP_PRELOAD_FOR_WRITE, 32'h2000, 32'h0, 6'h0, 16'h0, 14'h0);
    cmp(hq.size(), 0);
    mp_ext = 1'b1;
    hint_rdy = 1'b0;
    go(SPRA_OP_DATA_PRELOAD, 32'h3000, 32'h0, 6'h0, 16'h0, 14'h0);
    cmp(hq.size() + rq.size(), 0);
    hint_rdy = 1'b1;
  endtask
  task automatic t_stack;
    logic [3:0] ix[3] = '{4'h0, 4'h1, 4'hF};
    go(SPRA_OP_STACK_PUSH, 32'h100, 32'h0, 6'h0, 16'h8003, 14'h0);
    cmp(xq.size(), 3);
    for (int k = 0; k < 3; k++)
      cmp(xq[k], {1'b0, ix[k], 32'hF4 + 4 * k});
    cmp(sp_q, 32'hF4);
    go(SPRA_OP_STACK_POP, 32'h100, 32'h0, 6'h0, 16'h0005, 14'h0);
    cmp(xq[0], {1'b1, 4'h0, 32'h100});
    cmp(xq[1], {1'b1, 4'h2, 32'h104});
    cmp(sp_q, 32'h108);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    rst_in = 1'b1;
    send = 1'b0;
    mp_ext = 1'b1;
    hint_rdy = 1'b1;
    flag_clr = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_pack;
    t_word;
    t_lane;
    t_rev;
    t_hint;
    t_stack;
    conclude;
  end
  // run needs about 700 cycles
  initial begin
    repeat (6000) @(posedge clk_in);
    failures++;
    conclude;
  end
endmodule // testbench
